// >>> core/lfcr_pkg.sv
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

package lfcr_pkg;

  localparam int          REG_W          = 9;
  localparam int          NUM_CFG        = 7;
  localparam int          NUM_CHAN       = 3;

  // Register addresses on the command port.
  localparam logic [3:0]  ADDR_CFG0      = 4'h0;
  localparam logic [3:0]  ADDR_CFG1      = 4'h1;
  localparam logic [3:0]  ADDR_Y_TUNE    = 4'h2;
  localparam logic [3:0]  ADDR_Z_TUNE    = 4'h3;
  localparam logic [3:0]  ADDR_XY_SENS   = 4'h4;
  localparam logic [3:0]  ADDR_Z_SENS    = 4'h5;
  localparam logic [3:0]  ADDR_COLUMN    = 4'h6;
  localparam logic [3:0]  ADDR_STATUS    = 4'h7;

  // Reset value and Z tune write mask.
  localparam logic [8:0]  CFG_RESET      = 9'h000;
  localparam logic [8:0]  Z_TUNE_WMASK   = 9'h07F;

  // Field positions.
  localparam int          ROW_BIT        = 0;
  localparam int          ALERT_SEL_BIT  = 4;
  localparam int          CHAN_DIS_LSB   = 1;
  localparam int          OUT_TYPE_HI    = 8;
  localparam int          PULLDOWN_BIT   = 8;
  localparam int          DIV_BIT        = 7;
  localparam int          TUNE_LSB       = 1;
  localparam int          X_ATTEN_LSB    = 5;
  localparam int          LO_ATTEN_LSB   = 1;
  localparam int          AUTO_BIT       = 8;
  localparam int          GATE_BIT       = 7;
  localparam int          DEPTH_LSB      = 5;
  localparam int          COL_TOP        = 8;

  // Status bit positions.
  localparam int          ST_PASS_LSB    = 6;
  localparam int          ST_GAIN        = 5;
  localparam int          ST_WAKE_LSB    = 2;
  localparam int          ST_ALARM       = 1;
  localparam int          ST_CHECK       = 0;

  // Minimum modulation depth codes and their percentages.
  typedef enum logic [1:0] {
    LFCR_DEPTH_50 = 2'b00,
    LFCR_DEPTH_75 = 2'b01,
    LFCR_DEPTH_25 = 2'b10,
    LFCR_DEPTH_12 = 2'b11
  } lfcr_depth_t;

  localparam logic [6:0]  PCT_50         = 7'h32;
  localparam logic [6:0]  PCT_75         = 7'h4B;
  localparam logic [6:0]  PCT_25         = 7'h19;
  localparam logic [6:0]  PCT_12         = 7'h0C;

endpackage : lfcr_pkg

// >>> core/lfcr_sync.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////

module lfcr_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } lfcr_sync_state_t;

  lfcr_sync_state_t state;
  lfcr_sync_state_t next_state;
  logic [W-1:0]     agree;

  ////////////////////////////////////////////////////////////////////////////////

  // The first stage is read only by the second, so metastability cannot leak.
  always_comb begin
    agree            = ~(state.s2 ^ state.s3);
    next_state       = state;
    next_state.s1    = async_in;
    next_state.s2    = state.s1;
    next_state.s3    = state.s2;
    next_state.level = (state.s2 & agree) | (state.level & ~agree);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

endmodule : lfcr_sync

// >>> core/lfcr_regs.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////

module lfcr_regs (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire logic [3:0] cmd_addr,
  input  wire logic [8:0] cmd_wdata,
  output logic      [8:0] cmd_rdata,
  output logic            cmd_rvalid,
  input  wire logic       soft_reset_cmd,
  input  wire logic       standby,
  input  wire logic [2:0] pass_raw,
  input  wire logic       gain_active_raw,
  input  wire logic [2:0] demod_high_raw,
  input  wire logic [2:0] wake_raw,
  input  wire logic       alarm_raw,
  input  wire logic       stab_done_raw,
  output logic            pad_pulldown_on,
  output logic            carrier_div_sel,
  output logic      [5:0] y_tune_code,
  output logic      [5:0] z_tune_code,
  output logic      [3:0] x_atten_code,
  output logic      [3:0] y_atten_code,
  output logic      [3:0] z_atten_code,
  output logic            auto_channel_pick,
  output logic            gain_gated_output,
  output logic      [1:0] min_mod_depth,
  output logic      [6:0] min_depth_pct,
  output logic      [2:0] channel_enable,
  output logic            demod_out_enable,
  output logic            check_error_flag,
  output logic            alert_n
);

  typedef struct packed {
    logic [lfcr_pkg::NUM_CFG-1:0][lfcr_pkg::REG_W-1:0] cfg;
    logic [2:0]                                        passing;
    logic                                              gain_loop_active;
    logic [2:0]                                        woke;
    logic                                              alarm;
    logic [2:0]                                        wake_prev;
    logic                                              alarm_prev;
    logic                                              stab_prev;
    logic [2:0]                                        auto_pick;
    logic [8:0]                                        rdata;
    logic                                              rvalid;
    logic                                              pad_pulldown_on;
    logic                                              carrier_div_sel;
    logic [5:0]                                        y_tune_code;
    logic [5:0]                                        z_tune_code;
    logic [3:0]                                        x_atten_code;
    logic [3:0]                                        y_atten_code;
    logic [3:0]                                        z_atten_code;
    logic                                              auto_channel_pick;
    logic                                              gain_gated_output;
    logic [1:0]                                        min_mod_depth;
    logic [6:0]                                        min_depth_pct;
    logic [2:0]                                        channel_enable;
    logic                                              demod_out_enable;
  } lfcr_state_t;

  lfcr_state_t state;
  lfcr_state_t next_state;

  logic [11:0] raw_bus;
  logic [11:0] sync_bus;
  logic [2:0]  pass_s;
  logic        gain_s;
  logic [2:0]  demod_s;
  logic [2:0]  wake_s;
  logic        alarm_s;
  logic        stab_s;
  logic        row_bad;
  logic        col_bad;
  logic        check_err;
  logic [8:0]  col_sum;
  logic [8:0]  status_word;
  logic [8:0]  row_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // Front-end status inputs are analog-derived and arrive unsynchronised.

  assign raw_bus = {stab_done_raw, alarm_raw, wake_raw, demod_high_raw,
                    gain_active_raw, pass_raw};

  lfcr_sync #(
    .W (12)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (raw_bus),
    .level    (sync_bus)
  );

  assign pass_s  = sync_bus[2:0];
  assign gain_s  = sync_bus[3];
  assign demod_s = sync_bus[6:4];
  assign wake_s  = sync_bus[9:7];
  assign alarm_s = sync_bus[10];
  assign stab_s  = sync_bus[11];

  ////////////////////////////////////////////////////////////////////////////////
  // Parity over the stored array; no latch, so a bad write shows at once.

  always_comb begin
    row_bad  = 1'b0;
    col_sum  = '0;
    row_bits = '0;
    for (int r = 0; r < lfcr_pkg::NUM_CFG; r++) begin
      row_bad = row_bad | ~(^state.cfg[r]);
    end
    for (int r = 0; r < lfcr_pkg::NUM_CFG - 1; r++) begin
      col_sum     = col_sum ^ state.cfg[r];
      row_bits[r] = state.cfg[r][lfcr_pkg::ROW_BIT];
    end
    col_sum[lfcr_pkg::COL_TOP] = ^row_bits;
    col_sum[lfcr_pkg::ROW_BIT] = 1'b0;
    col_bad = 1'b0;
    for (int b = 1; b <= lfcr_pkg::COL_TOP; b++) begin
      col_bad = col_bad | ~(col_sum[b] ^ state.cfg[lfcr_pkg::NUM_CFG-1][b]);
    end
    check_err = row_bad | col_bad;
  end

  // Only the parity flag is live from the array; the rest are stored flags.
  assign status_word = {state.passing[2], state.passing[1], state.passing[0],
                        state.gain_loop_active,
                        state.woke[2], state.woke[1], state.woke[0],
                        state.alarm, check_err};

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic       soft_go;
    logic [2:0] wake_evt;
    logic       alarm_evt;
    logic       stab_evt;
    logic       status_rd;
    logic [8:0] rdv;

    soft_go   = 1'b0;
    wake_evt  = '0;
    alarm_evt = 1'b0;
    stab_evt  = 1'b0;
    status_rd = 1'b0;
    rdv       = '0;

    next_state = state;

    // Soft reset only executes while the front end is active.
    soft_go   = soft_reset_cmd & ~standby;
    wake_evt  = wake_s & ~state.wake_prev;
    alarm_evt = alarm_s & ~state.alarm_prev;
    stab_evt  = stab_s & ~state.stab_prev;
    status_rd = cmd_rd & (cmd_addr == lfcr_pkg::ADDR_STATUS);

    next_state.wake_prev  = wake_s;
    next_state.alarm_prev = alarm_s;
    next_state.stab_prev  = stab_s;

    // Register writes; status and unmapped addresses are ignored.
    if (cmd_wr) begin
      if (cmd_addr == lfcr_pkg::ADDR_Z_TUNE) begin
        next_state.cfg[cmd_addr[2:0]] = cmd_wdata & lfcr_pkg::Z_TUNE_WMASK;
      end else if (cmd_addr < lfcr_pkg::ADDR_STATUS) begin
        next_state.cfg[cmd_addr[2:0]] = cmd_wdata;
      end
    end

    // Read path.
    if (cmd_addr == lfcr_pkg::ADDR_STATUS) begin
      rdv = status_word;
    end else if (cmd_addr < lfcr_pkg::ADDR_STATUS) begin
      rdv = state.cfg[cmd_addr[2:0]];
    end else begin
      rdv = '0;
    end
    next_state.rvalid = cmd_rd;
    if (cmd_rd) begin
      next_state.rdata = rdv;
    end

    // Channel activity follows the front end but reads low in standby.
    if (soft_go) begin
      next_state.passing = '0;
    end else begin
      next_state.passing = pass_s & {3{~standby}};
    end

    if (soft_go) begin
      next_state.gain_loop_active = 1'b0;
    end else begin
      next_state.gain_loop_active = gain_s;
    end

    // A wake arriving with the soft reset is kept: the set wins.
    next_state.woke = (state.woke & {3{~soft_go}}) | wake_evt;

    // Alarm is cleared only by a status read, and a fresh time-out wins.
    next_state.alarm = (state.alarm & ~status_rd) | alarm_evt;

    // Auto channel pick samples the demodulators at the end of stabilization.
    if (stab_evt) begin
      next_state.auto_pick = demod_s;
    end else if (soft_go) begin
      next_state.auto_pick = '0;
    end

    // Registered control outputs, taken from the stored configuration.
    next_state.pad_pulldown_on =
      state.cfg[2][lfcr_pkg::PULLDOWN_BIT] & state.cfg[1][lfcr_pkg::OUT_TYPE_HI];
    next_state.carrier_div_sel = state.cfg[2][lfcr_pkg::DIV_BIT];
    next_state.y_tune_code     = state.cfg[2][lfcr_pkg::TUNE_LSB +: 6];
    next_state.z_tune_code     = state.cfg[3][lfcr_pkg::TUNE_LSB +: 6];
    next_state.x_atten_code    = state.cfg[4][lfcr_pkg::X_ATTEN_LSB +: 4];
    next_state.y_atten_code    = state.cfg[4][lfcr_pkg::LO_ATTEN_LSB +: 4];
    next_state.z_atten_code    = state.cfg[5][lfcr_pkg::LO_ATTEN_LSB +: 4];
    next_state.auto_channel_pick = state.cfg[5][lfcr_pkg::AUTO_BIT];
    next_state.gain_gated_output = state.cfg[5][lfcr_pkg::GATE_BIT];
    next_state.min_mod_depth     = state.cfg[5][lfcr_pkg::DEPTH_LSB +: 2];

    case (lfcr_pkg::lfcr_depth_t'(state.cfg[5][lfcr_pkg::DEPTH_LSB +: 2]))
      lfcr_pkg::LFCR_DEPTH_50: begin
        next_state.min_depth_pct = lfcr_pkg::PCT_50;
      end
      lfcr_pkg::LFCR_DEPTH_75: begin
        next_state.min_depth_pct = lfcr_pkg::PCT_75;
      end
      lfcr_pkg::LFCR_DEPTH_25: begin
        next_state.min_depth_pct = lfcr_pkg::PCT_25;
      end
      default: begin
        next_state.min_depth_pct = lfcr_pkg::PCT_12;
      end
    endcase

    // Enable bits in register 0 are active low.
    if (state.cfg[5][lfcr_pkg::AUTO_BIT]) begin
      next_state.channel_enable = state.auto_pick;
    end else begin
      next_state.channel_enable = ~state.cfg[0][lfcr_pkg::CHAN_DIS_LSB +: 3];
    end

    // Gating holds the demodulator off until the gain loop regulates.
    next_state.demod_out_enable =
      ~state.cfg[5][lfcr_pkg::GATE_BIT] | state.gain_loop_active;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alert is combinational so a parity fault is flagged the cycle it appears.

  assign check_error_flag = check_err;
  assign alert_n = ~(check_err |
                     (state.cfg[0][lfcr_pkg::ALERT_SEL_BIT] & state.alarm));

  assign cmd_rdata         = state.rdata;
  assign cmd_rvalid        = state.rvalid;
  assign pad_pulldown_on   = state.pad_pulldown_on;
  assign carrier_div_sel   = state.carrier_div_sel;
  assign y_tune_code       = state.y_tune_code;
  assign z_tune_code       = state.z_tune_code;
  assign x_atten_code      = state.x_atten_code;
  assign y_atten_code      = state.y_atten_code;
  assign z_atten_code      = state.z_atten_code;
  assign auto_channel_pick = state.auto_channel_pick;
  assign gain_gated_output = state.gain_gated_output;
  assign min_mod_depth     = state.min_mod_depth;
  assign min_depth_pct     = state.min_depth_pct;
  assign channel_enable    = state.channel_enable;
  assign demod_out_enable  = state.demod_out_enable;

endmodule : lfcr_regs

// >>> dv/lfcr_regs_checker.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module lfcr_regs_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire logic [3:0] cmd_addr,
  input wire logic [8:0] cmd_wdata,
  input wire logic [8:0] cmd_rdata,
  input wire logic       cmd_rvalid,
  input wire logic       carrier_div_sel,
  input wire logic [5:0] y_tune_code,
  input wire logic [5:0] z_tune_code,
  input wire logic [3:0] x_atten_code,
  input wire logic [1:0] min_mod_depth,
  input wire logic [6:0] min_depth_pct,
  input wire logic       gain_gated_output,
  input wire logic       demod_out_enable,
  input wire logic       check_error_flag,
  input wire logic       alert_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_read_answer: assert property (cmd_rd |=> cmd_rvalid)
    else $error("read not answered");
  a_no_spurious: assert property (!cmd_rd |=> !cmd_rvalid)
    else $error("answer without read");
  a_unmapped_zero: assert property (cmd_rd && cmd_addr[3] |=> cmd_rdata == 9'h000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (cmd_rd && cmd_addr == 4'h3 |=> cmd_rdata[8:7] == 2'h0)
    else $error("unimplemented bits read nonzero");
  a_div_follow: assert property (cmd_wr && cmd_addr == 4'h2 |->
    ##2 carrier_div_sel == $past(cmd_wdata[7], 2)) else $error("divider select wrong");
  a_y_tune: assert property (cmd_wr && cmd_addr == 4'h2 |->
    ##2 y_tune_code == $past(cmd_wdata[6:1], 2)) else $error("y tuning code wrong");
  a_z_tune: assert property (cmd_wr && cmd_addr == 4'h3 |->
    ##2 z_tune_code == $past(cmd_wdata[6:1], 2)) else $error("z tuning code wrong");
  a_x_atten: assert property (cmd_wr && cmd_addr == 4'h4 |->
    ##2 x_atten_code == $past(cmd_wdata[8:5], 2)) else $error("x attenuation wrong");
  a_depth_map: assert property (!$past(rst) |-> min_depth_pct ==
    (min_mod_depth == 2'h0 ? 7'h32 : min_mod_depth == 2'h1 ? 7'h4B :
     min_mod_depth == 2'h2 ? 7'h19 : 7'h0C)) else $error("depth percent wrong");
  a_alert_error: assert property (check_error_flag |-> !alert_n)
    else $error("alert high during parity error");
  a_gate_open: assert property (!$past(rst) && !gain_gated_output |-> demod_out_enable)
    else $error("output gated while gating is off");
endmodule : lfcr_regs_checker

bind lfcr_regs lfcr_regs_checker u_lfcr_regs_checker (.ref_clk, .rst, .cmd_wr, .cmd_rd,
  .cmd_addr, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .carrier_div_sel, .y_tune_code,
  .z_tune_code, .x_atten_code, .min_mod_depth, .min_depth_pct, .gain_gated_output,
  .demod_out_enable, .check_error_flag, .alert_n);

// >>> dv/lfcr_host.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module lfcr_host (
  input  wire logic       ref_clk,
  input  wire logic [8:0] cmd_rdata,
  input  wire logic       cmd_rvalid,
  output logic            cmd_wr,
  output logic            cmd_rd,
  output logic      [3:0] cmd_addr,
  output logic      [8:0] cmd_wdata
);
  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_addr  = 4'h0;
    cmd_wdata = 9'h000;
  end

  // Data is inverted after each write so a stale word is never mistaken for a fresh one.
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    @(negedge ref_clk);
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_wr    = 1'b1;
    @(negedge ref_clk);
    cmd_wr    = 1'b0;
    cmd_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [8:0] d);
    @(negedge ref_clk);
    cmd_addr = a;
    cmd_rd   = 1'b1;
    @(negedge ref_clk);
    cmd_rd   = 1'b0;
    d        = (cmd_rvalid === 1'b1) ? cmd_rdata : 'x;
  endtask : rd
endmodule : lfcr_host

// >>> dv/testbench.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic       ref_clk, rst, cmd_wr, cmd_rd, cmd_rvalid, soft_reset_cmd, standby;
  logic       gain_active_raw, alarm_raw, stab_done_raw, pad_pulldown_on, carrier_div_sel;
  logic       auto_channel_pick, gain_gated_output, demod_out_enable, check_error_flag, alert_n;
  logic [3:0] cmd_addr, x_atten_code, y_atten_code, z_atten_code;
  logic [8:0] cmd_wdata, cmd_rdata;
  logic [2:0] pass_raw, demod_high_raw, wake_raw, channel_enable;
  logic [5:0] y_tune_code, z_tune_code;
  logic [1:0] min_mod_depth;
  logic [6:0] min_depth_pct;
  logic [8:0] cfg [0:6];
  logic [6:0] pct [0:3] = '{7'h32, 7'h4B, 7'h19, 7'h0C};
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cyc = 0;

  lfcr_regs u_lfcr_regs (.ref_clk, .rst, .cmd_wr, .cmd_rd, .cmd_addr, .cmd_wdata, .cmd_rdata,
    .cmd_rvalid, .soft_reset_cmd, .standby, .pass_raw, .gain_active_raw, .demod_high_raw,
    .wake_raw, .alarm_raw, .stab_done_raw, .pad_pulldown_on, .carrier_div_sel, .y_tune_code,
    .z_tune_code, .x_atten_code, .y_atten_code, .z_atten_code, .auto_channel_pick,
    .gain_gated_output, .min_mod_depth, .min_depth_pct, .channel_enable, .demod_out_enable,
    .check_error_flag, .alert_n);
  lfcr_host u_lfcr_host (.ref_clk, .cmd_rdata, .cmd_rvalid, .cmd_wr, .cmd_rd, .cmd_addr,
    .cmd_wdata);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // The run is under two hundred cycles; the ceiling leaves ample margin.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic wcfg(logic [3:0] a, logic [7:0] d);
    cfg[a] = {d, ~^d};
    if (a == 4'h3) cfg[a][8:7] = 2'h0;
    u_lfcr_host.wr(a, {d, ~^d});
  endtask : wcfg

  task automatic fixcol();
    logic [7:0] c;
    for (int j = 1; j <= 8; j++) begin
      c[j-1] = 1'b1;
      for (int r = 0; r < 6; r++) c[j-1] ^= cfg[r][j % 8];
    end
    wcfg(4'h6, c);
  endtask : fixcol

  task automatic rchk(logic [3:0] a, logic [8:0] exp, string what);
    logic [8:0] d;
    u_lfcr_host.rd(a, d);
    check(what, d, exp);
  endtask : rchk

  task automatic pulse_alarm();
    @(negedge ref_clk) alarm_raw = 1'b1;
    idle(3);
    alarm_raw = 1'b0;
    idle(6);
  endtask : pulse_alarm

  initial begin
    {rst, soft_reset_cmd, standby, gain_active_raw, alarm_raw, stab_done_raw} = 6'h20;
    {pass_raw, demod_high_raw, wake_raw} = 9'h000;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    idle(2);
    rchk(4'h7, 9'h001, "status after reset");
    check("alert", 9'(alert_n), 9'h000);
    check("enables", 9'(channel_enable), 9'h007);
    $display("test reset done");
    wcfg(4'h0, 8'h00);
    wcfg(4'h1, 8'h80);
    wcfg(4'h2, 8'hEA);
    wcfg(4'h3, 8'hFF);
    wcfg(4'h4, 8'hF5);
    wcfg(4'h5, 8'h5C);
    fixcol();
    idle(2);
    check("flag", 9'(check_error_flag), 9'h000);
    check("alert", 9'(alert_n), 9'h001);
    check("pulldown", 9'(pad_pulldown_on), 9'h001);
    check("divider", 9'(carrier_div_sel), 9'h001);
    check("y tune", 9'(y_tune_code), 9'h02A);
    check("z tune", 9'(z_tune_code), 9'h03F);
    check("x atten", 9'(x_atten_code), 9'h00F);
    check("y atten", 9'(y_atten_code), 9'h005);
    check("z atten", 9'(z_atten_code), 9'h00C);
    check("gating", 9'(gain_gated_output), 9'h001);
    check("depth", 9'(min_mod_depth), 9'h001);
    for (int a = 0; a < 7; a++) rchk(4'(a), cfg[a], "readback");
    u_lfcr_host.wr(4'h7, 9'h1FF);
    rchk(4'h7, 9'h000, "status write");
    rchk(4'h9, 9'h000, "unmapped");
    wcfg(4'h1, 8'h00);
    idle(2);
    check("pulldown mode", 9'(pad_pulldown_on), 9'h000);
    wcfg(4'h1, 8'h80);
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      wcfg(4'h5, {2'h1, 2'(i), 4'hC});
      idle(2);
      check("percent", 9'(min_depth_pct), 9'(pct[i]));
      check("column", 9'(check_error_flag), 9'(i != 1));
    end
    wcfg(4'h5, 8'h5C);
    u_lfcr_host.wr(4'h2, 9'h1D5);
    rchk(4'h7, 9'h001, "row error");
    check("alert", 9'(alert_n), 9'h000);
    wcfg(4'h2, 8'hEA);
    idle(1);
    check("flag", 9'(check_error_flag), 9'h000);
    $display("test parity done");
    pulse_alarm();
    check("alert off", 9'(alert_n), 9'h001);
    rchk(4'h7, 9'h002, "alarm");
    wcfg(4'h0, 8'h08);
    fixcol();
    pulse_alarm();
    check("alert", 9'(alert_n), 9'h000);
    rchk(4'h7, 9'h002, "alarm");
    check("alert", 9'(alert_n), 9'h001);
    rchk(4'h7, 9'h000, "alarm cleared");
    $display("test alarm done");
    {pass_raw, gain_active_raw, wake_raw} = 7'h5A;
    idle(6);
    rchk(4'h7, 9'h168, "live status");
    check("demod on", 9'(demod_out_enable), 9'h001);
    pulse_alarm();
    {pass_raw, gain_active_raw} = 4'h0;
    idle(6);
    check("demod off", 9'(demod_out_enable), 9'h000);
    @(negedge ref_clk) soft_reset_cmd = 1'b1;
    @(negedge ref_clk) soft_reset_cmd = 1'b0;
    idle(1);
    rchk(4'h7, 9'h002, "soft reset");
    pass_raw = 3'h7;
    standby = 1'b1;
    idle(6);
    rchk(4'h7, 9'h000, "standby");
    {standby, pass_raw} = 4'h0;
    $display("test status done");
    wcfg(4'h5, 8'hDC);
    demod_high_raw = 3'h3;
    @(negedge ref_clk) stab_done_raw = 1'b1;
    idle(6);
    check("auto pick", 9'(channel_enable), 9'h003);
    check("auto bit", 9'(auto_channel_pick), 9'h001);
    wcfg(4'h5, 8'h5C);
    idle(2);
    check("manual", 9'(channel_enable), 9'h007);
    check("auto bit", 9'(auto_channel_pick), 9'h000);
    $display("test auto done");
    complete_run();
  end
endmodule : testbench
